// >>> rtl/hvcse_pkg.sv
// Shared constants and types for the channel status and event bank
package hvcse_pkg;

	localparam int WORD_W = 16;

	// Bit positions shared by the live status and the latched event word
	localparam int BIT_VOLT_MAX  = 15;
	localparam int BIT_AMP_MAX   = 14;
	localparam int BIT_KILL      = 13;
	localparam int BIT_EXT_BLOCK = 12;
	localparam int BIT_VOLT_WIN  = 11;
	localparam int BIT_AMP_WIN   = 10;
	localparam int BIT_ARC_COUNT = 9;
	localparam int BIT_RES_HI    = 8;
	localparam int BIT_CV        = 7;
	localparam int BIT_CC        = 6;
	localparam int BIT_PANIC     = 5;
	localparam int BIT_RAMP      = 4;
	localparam int BIT_LIVE      = 3;
	localparam int BIT_BAD_INPUT = 2;
	localparam int BIT_ARC       = 1;
	localparam int BIT_RES_LO    = 0;

	localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] EVENT_RESET  = 16'h0000;
	localparam logic [WORD_W-1:0] USED_MASK    = 16'hFEFE;
	// Latched events that keep the output from being switched on
	localparam logic [WORD_W-1:0] BLOCK_MASK   = 16'hFE20;

	// Output counts as live above this measured voltage
	localparam int LIVE_THRESH_V = 60;

	// Live conditions reported by the channel control logic
	typedef struct packed {
		logic volt_max_exceeded;
		logic amp_max_exceeded;
		logic kill_enable;
		logic amp_setpoint_hit;
		logic abrupt_shutdown;
		logic volt_window_violation;
		logic amp_window_violation;
		logic arc_count_fault;
		logic cv_regulation;
		logic cc_regulation;
		logic panic_cutoff;
		logic ramp_in_progress;
		logic hv_generating;
		logic bad_input_flag;
		logic arc_present;
	} hvcse_cond_t;

	// Host commands: one-cycle strobes, plus the ack_data word that goes with ack_write
	typedef struct packed {
		logic              ack_write;
		logic [WORD_W-1:0] ack_data;
		logic              clear_events;
		logic              global_clear_cmd;
		logic              switch_on_req;
	} hvcse_cmd_t;

endpackage : hvcse_pkg

// >>> rtl/hvcse_sync.sv
// Two-flop level synchroniser, one stage pair per bit
module hvcse_sync
	import hvcse_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	if (WIDTH < 1) begin : g_check
		$error("hvcse_sync needs WIDTH of at least one");
	end

	logic [WIDTH-1:0] meta;

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta[i]     <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta[i]     <= async_in[i];
				sync_out[i] <= meta[i];
			end
		end
	end

endmodule : hvcse_sync

// >>> rtl/hvcse_bank.sv
// Channel live status word, sticky event word and switch-on gate
module hvcse_bank
	import hvcse_pkg::*;
#(
	parameter int VOLT_W = 16
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire hvcse_cond_t       cond,
	input  wire logic [VOLT_W-1:0] volt_meas,
	input  wire logic              ext_block_pin,
	input  wire hvcse_cmd_t        cmd,
	output logic [WORD_W-1:0]      channel_live_status,
	output logic [WORD_W-1:0]      channel_latched_events,
	output logic                   switch_on_blocked,
	output logic                   switch_on_grant,
	output logic                   switch_on_refused,
	output logic                   module_events_clear
);

	// A window narrower than the threshold could never report a live output
	if (VOLT_W < 7 || VOLT_W > 32) begin : g_check
		$error("hvcse_bank needs VOLT_W between 7 and 32");
	end

	localparam logic [VOLT_W-1:0] LIVE_THRESH = VOLT_W'(LIVE_THRESH_V);

	// Inhibit arrives from a pin, so it is synchronised first
	logic ext_block_active;

	hvcse_sync #(
		.WIDTH (1)
	) u_ext_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (ext_block_pin),
		.sync_out (ext_block_active)
	);

	// Kill-mode shutdown, held until the condition is gone and off is done
	logic kill_shutdown_flag;
	logic next_kill_shutdown_flag;
	logic kill_cause;

	always_comb begin
		kill_cause = cond.volt_max_exceeded
			| cond.amp_max_exceeded
			| cond.amp_setpoint_hit;
		next_kill_shutdown_flag = kill_shutdown_flag;
		if (cond.kill_enable && kill_cause && cond.abrupt_shutdown) begin
			next_kill_shutdown_flag = 1'b1;
		end else if (!cond.hv_generating && !kill_cause) begin
			next_kill_shutdown_flag = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kill_shutdown_flag <= 1'b0;
		end else begin
			kill_shutdown_flag <= next_kill_shutdown_flag;
		end
	end

	// Live status word
	logic [WORD_W-1:0] next_status;
	logic              output_live;

	always_comb begin
		output_live = cond.hv_generating || (volt_meas > LIVE_THRESH);
		next_status = STATUS_RESET;
		next_status[BIT_VOLT_MAX]  = cond.volt_max_exceeded;
		next_status[BIT_AMP_MAX]   = cond.amp_max_exceeded;
		next_status[BIT_KILL]      = kill_shutdown_flag;
		next_status[BIT_EXT_BLOCK] = ext_block_active;
		next_status[BIT_VOLT_WIN]  = cond.volt_window_violation;
		next_status[BIT_AMP_WIN]   = cond.amp_window_violation;
		next_status[BIT_ARC_COUNT] = cond.arc_count_fault;
		next_status[BIT_CV]        = cond.cv_regulation;
		next_status[BIT_CC]        = cond.cc_regulation;
		next_status[BIT_PANIC]     = cond.panic_cutoff;
		next_status[BIT_RAMP]      = cond.ramp_in_progress;
		next_status[BIT_LIVE]      = output_live;
		next_status[BIT_BAD_INPUT] = cond.bad_input_flag;
		next_status[BIT_ARC]       = cond.arc_present;
		next_status = next_status & USED_MASK;
	end

	// Re-evaluated every cycle with no software involvement
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_live_status <= STATUS_RESET;
		end else begin
			channel_live_status <= next_status;
		end
	end

	// Previous status, for edge-driven events
	logic [WORD_W-1:0] prev_status;
	logic [WORD_W-1:0] next_prev_status;

	always_comb begin
		next_prev_status = channel_live_status;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_status <= STATUS_RESET;
		end else begin
			prev_status <= next_prev_status;
		end
	end

	// Event set vector
	logic [WORD_W-1:0] event_set;
	logic              ramp_finished;
	logic              cut_without_ramp;
	logic [WORD_W-1:0] rose;

	always_comb begin
		rose = channel_live_status & ~prev_status;
		// Ramp-end is an edge, not a level
		ramp_finished = prev_status[BIT_RAMP] & ~channel_live_status[BIT_RAMP];
		// Every unramped cutoff cause counts as an abrupt off
		cut_without_ramp = rose[BIT_KILL]
			| rose[BIT_PANIC]
			| rose[BIT_ARC_COUNT];
		event_set = channel_live_status;
		event_set[BIT_RAMP] = ramp_finished;
		event_set[BIT_LIVE] = cut_without_ramp;
		event_set = event_set & USED_MASK;
	end

	// Individual event names
	logic volt_max_latched;
	logic amp_max_latched;
	logic kill_shutdown_latched;
	logic ext_block_latched;
	logic volt_window_latched;
	logic amp_window_latched;
	logic arc_count_latched;
	logic cv_latched;
	logic cc_latched;
	logic panic_cutoff_latched;
	logic ramp_done_latched;
	logic abrupt_off_latched;
	logic bad_input_latched;
	logic arc_seen_latched;

	always_comb begin
		volt_max_latched      = event_set[BIT_VOLT_MAX];
		amp_max_latched       = event_set[BIT_AMP_MAX];
		kill_shutdown_latched = event_set[BIT_KILL];
		ext_block_latched     = event_set[BIT_EXT_BLOCK];
		volt_window_latched   = event_set[BIT_VOLT_WIN];
		amp_window_latched    = event_set[BIT_AMP_WIN];
		arc_count_latched     = event_set[BIT_ARC_COUNT];
		cv_latched            = event_set[BIT_CV];
		cc_latched            = event_set[BIT_CC];
		panic_cutoff_latched  = event_set[BIT_PANIC];
		ramp_done_latched     = event_set[BIT_RAMP];
		abrupt_off_latched    = event_set[BIT_LIVE];
		bad_input_latched     = event_set[BIT_BAD_INPUT];
		arc_seen_latched      = event_set[BIT_ARC];
	end

	// Sticky event word; a set in the clearing cycle wins over the clear
	logic [WORD_W-1:0] next_events;
	logic [WORD_W-1:0] set_vec;
	logic [WORD_W-1:0] clr_vec;

	always_comb begin
		set_vec = {volt_max_latched, amp_max_latched, kill_shutdown_latched,
			ext_block_latched, volt_window_latched, amp_window_latched,
			arc_count_latched, 1'b0, cv_latched, cc_latched,
			panic_cutoff_latched, ramp_done_latched, abrupt_off_latched,
			bad_input_latched, arc_seen_latched, 1'b0};
		clr_vec = {WORD_W{1'b0}};
		if (cmd.ack_write) begin
			clr_vec = cmd.ack_data;
		end
		if (cmd.clear_events) begin
			clr_vec = {WORD_W{1'b1}};
		end
		if (cmd.global_clear_cmd) begin
			clr_vec = {WORD_W{1'b1}};
		end
		// Never cleared by hardware itself
		next_events = ((channel_latched_events & ~clr_vec) | set_vec) & USED_MASK;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_latched_events <= EVENT_RESET;
		end else begin
			channel_latched_events <= next_events;
		end
	end

	// Module-level event word lives elsewhere; it is told by this pulse
	logic next_module_events_clear;

	always_comb begin
		next_module_events_clear = cmd.global_clear_cmd;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			module_events_clear <= 1'b0;
		end else begin
			module_events_clear <= next_module_events_clear;
		end
	end

	// Switch-on gate, judged on the event word as updated this cycle
	logic next_blocked;
	logic next_grant;
	logic next_refused;

	always_comb begin
		next_blocked = |(next_events & BLOCK_MASK);
		// Clearing and switching on in one cycle: the clear counts first
		next_grant   = cmd.switch_on_req & ~next_blocked;
		next_refused = cmd.switch_on_req & next_blocked;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			switch_on_blocked <= 1'b0;
			switch_on_grant   <= 1'b0;
			switch_on_refused <= 1'b0;
		end else begin
			switch_on_blocked <= next_blocked;
			switch_on_grant   <= next_grant;
			switch_on_refused <= next_refused;
		end
	end

endmodule : hvcse_bank

// >>> sim/hvcse_bank_props.sv
// Assertion checker for the channel status and event bank
module hvcse_bank_props
	import hvcse_pkg::*;
#(
	parameter int VOLT_W = 16
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire hvcse_cond_t       cond,
	input wire logic [VOLT_W-1:0] volt_meas,
	input wire logic              ext_block_pin,
	input wire hvcse_cmd_t        cmd,
	input wire logic [WORD_W-1:0] channel_live_status,
	input wire logic [WORD_W-1:0] channel_latched_events,
	input wire logic              switch_on_blocked,
	input wire logic              switch_on_grant,
	input wire logic              switch_on_refused,
	input wire logic              module_events_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [WORD_W-1:0] st;
	logic [WORD_W-1:0] ev;
	assign st = channel_live_status;
	assign ev = channel_latched_events;

	chk_volt_max_live: assert property (1 |=> st[15] == $past(cond.volt_max_exceeded))
		else $error("volt max status wrong");
	chk_live_thresh: assert property (1 |=> st[BIT_LIVE] ==
		($past(cond.hv_generating) || ($past(volt_meas) > LIVE_THRESH_V)))
		else $error("live status wrong");
	chk_reserved_zero: assert property (!(st[8] || st[0] || ev[8] || ev[0]))
		else $error("reserved bit set");
	chk_event_sets: assert property (1 |=> (ev & $past(st) & 16'hFFE6) ==
		($past(st) & 16'hFFE6))
		else $error("event missed its status");
	chk_event_sticky: assert property
		(!(cmd.ack_write || cmd.clear_events || cmd.global_clear_cmd) |=>
		(ev & $past(ev)) == $past(ev))
		else $error("event cleared by itself");
	chk_ramp_done: assert property ($fell(st[BIT_RAMP]) |=> ev[BIT_RAMP])
		else $error("end of ramp not latched");
	chk_abrupt_off: assert property
		($rose(st[13]) || $rose(st[5]) || $rose(st[9]) |=> ev[BIT_LIVE])
		else $error("abrupt off not latched");
	chk_ext_delay: assert property
		($rose(ext_block_pin) ##1 ext_block_pin [*2] |=> st[BIT_EXT_BLOCK])
		else $error("inhibit status late");
	chk_blocked_level: assert property (switch_on_blocked == |(ev & BLOCK_MASK))
		else $error("blocked level wrong");
	chk_switch_answer: assert property (cmd.switch_on_req |=>
		switch_on_refused == |(ev & BLOCK_MASK) && switch_on_grant == !switch_on_refused)
		else $error("switch-on answer wrong");
	chk_global_pulse: assert property (1 |=> module_events_clear == $past(cmd.global_clear_cmd))
		else $error("module clear pulse wrong");
	chk_clear_all: assert property ((cmd.clear_events || cmd.global_clear_cmd) |=>
		(ev & ~$past(st) & 16'hFFE6) == 16'h0000)
		else $error("clear left an event set");
endmodule : hvcse_bank_props

bind hvcse_bank hvcse_bank_props #(.VOLT_W(VOLT_W)) i_props (.clk(clk), .rst_n(rst_n),
	.cond(cond), .volt_meas(volt_meas), .ext_block_pin(ext_block_pin), .cmd(cmd),
	.channel_live_status(channel_live_status), .channel_latched_events(channel_latched_events),
	.switch_on_blocked(switch_on_blocked), .switch_on_grant(switch_on_grant),
	.switch_on_refused(switch_on_refused), .module_events_clear(module_events_clear));

// >>> sim/tb_hvcse_bank.sv
// Self-checking bench for the channel status and event bank
module tb_hvcse_bank
	import hvcse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk;
	logic              rst_n;
	hvcse_cond_t       cond;
	logic [15:0]       volt_meas;
	logic              ext_block_pin;
	hvcse_cmd_t        cmd;
	logic [WORD_W-1:0] st;
	logic [WORD_W-1:0] ev;
	logic              blk;
	logic              grant;
	logic              refused;
	logic              mclr;
	int                mismatches = 0;
	int                cmp_count = 0;
	int                cycles = 0;

	hvcse_bank #(.VOLT_W(16)) i_dut (.clk(clk), .rst_n(rst_n), .cond(cond),
		.volt_meas(volt_meas), .ext_block_pin(ext_block_pin), .cmd(cmd),
		.channel_live_status(st), .channel_latched_events(ev), .switch_on_blocked(blk),
		.switch_on_grant(grant), .switch_on_refused(refused), .module_events_clear(mclr));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	// Whole run is about 140 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Sample at the falling edge so every update has landed
	task automatic nxt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : nxt

	task automatic bit_walk();
		logic [15:0] s;
		logic [15:0] e;
		int pos [15] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, -1, -1, -1, 14, 15};
		for (int k = 0; k < 15; k++) begin
			if (pos[k] >= 0) begin
				s = 16'h0001 << pos[k];
				e = s & 16'hFFE6;
				if ((s & 16'h0220) != 16'h0000)
					e = e | 16'h0008;
				@(posedge clk) cond <= hvcse_cond_t'(15'h0001 << k);
				nxt(1);
				chk("status", s, st);
				nxt(1);
				chk("events", e, ev);
				chk("blocked", {15'h0000, |(e & BLOCK_MASK)}, {15'h0000, blk});
				@(posedge clk) cond <= '0;
				nxt(2);
				if (k == 3)
					e = e | 16'h0010;
				chk("held", e, ev);
				@(posedge clk) cmd.ack_write <= 1'b1;
				cmd.ack_data <= e;
				@(posedge clk) cmd.ack_write <= 1'b0;
				nxt(0);
				chk("acked", 16'h0000, ev);
			end
		end
	endtask : bit_walk

	task automatic live_thresh();
		@(posedge clk) volt_meas <= 16'h003C;
		nxt(1);
		chk("live_at_60", 16'h0000, st);
		@(posedge clk) volt_meas <= 16'h003D;
		nxt(1);
		chk("live_at_61", 16'h0008, st);
		@(posedge clk) volt_meas <= 16'h0000;
		nxt(1);
	endtask : live_thresh

	// Trip blocks switch-on until a clear lands with the request
	task automatic trip_gate();
		@(posedge clk) cond <= hvcse_cond_t'(15'h1C00);
		nxt(2);
		chk("trip", 16'h2000, st);
		@(posedge clk) cond <= '0;
		nxt(2);
		chk("trip_ev", 16'h2008, ev);
		@(posedge clk) cmd.ack_write <= 1'b1;
		cmd.ack_data <= 16'h0008;
		@(posedge clk) cmd.ack_write <= 1'b0;
		nxt(0);
		chk("partial_ack", 16'h2000, ev);
		chk("still_blocked", 16'h0001, {15'h0000, blk});
		@(posedge clk) cmd.switch_on_req <= 1'b1;
		@(posedge clk) cmd.clear_events <= 1'b1;
		nxt(0);
		chk("refused", 16'h0001, {15'h0000, refused});
		chk("no_grant", 16'h0000, {15'h0000, grant});
		@(posedge clk) cmd.switch_on_req <= 1'b0;
		cmd.clear_events <= 1'b0;
		nxt(0);
		chk("granted", 16'h0001, {15'h0000, grant});
		chk("no_refuse", 16'h0000, {15'h0000, refused});
		chk("cleared", 16'h0000, ev);
	endtask : trip_gate

	task automatic inhibit_clear();
		@(posedge clk) ext_block_pin <= 1'b1;
		nxt(3);
		chk("inhibit", 16'h1000, st);
		@(posedge clk) ext_block_pin <= 1'b0;
		nxt(4);
		chk("inhibit_ev", 16'h1000, ev);
		@(posedge clk) cmd.global_clear_cmd <= 1'b1;
		@(posedge clk) cmd.global_clear_cmd <= 1'b0;
		nxt(0);
		chk("mod_clear", 16'h0001, {15'h0000, mclr});
		chk("global_ev", 16'h0000, ev);
		nxt(1);
		chk("mod_clear_end", 16'h0000, {15'h0000, mclr});
	endtask : inhibit_clear

	// A clear in the cycle of a live condition leaves that event set
	task automatic set_wins();
		@(posedge clk) cond <= hvcse_cond_t'(15'h0040);
		nxt(2);
		chk("cv_ev", 16'h0080, ev);
		@(posedge clk) cmd.clear_events <= 1'b1;
		@(posedge clk) cmd.clear_events <= 1'b0;
		nxt(0);
		chk("set_wins", 16'h0080, ev);
		@(posedge clk) cond <= '0;
		nxt(1);
		@(posedge clk) cmd.clear_events <= 1'b1;
		@(posedge clk) cmd.clear_events <= 1'b0;
		nxt(0);
		chk("clear_all", 16'h0000, ev);
	endtask : set_wins

	initial begin
		rst_n = 1'b0;
		cond = '0;
		volt_meas = 16'h0000;
		ext_block_pin = 1'b0;
		cmd = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		fork
			begin
				nxt(1);
				chk("reset", 16'h0000, st | ev);
				bit_walk();
				live_thresh();
				trip_gate();
				inhibit_clear();
				set_wins();
			end
			begin
				wait (cycles == 2000);
				mismatches++;
				$display("mismatch timeout expected %0d seen %0d", 2000, cycles);
			end
		join_any
		close_out();
	end
endmodule : tb_hvcse_bank
